// >>> logic/abx_alu.sv
// Combinational datapath for the add / AND / bit-op group.
// Assumes operands are already resolved (pin levels, forwarding) by the caller.

`timescale 1ns/1ps

module abx_alu (
  input  wire abx_pkg::abx_op_t      op,
  input  wire logic [7:0]            w_value,
  input  wire logic [7:0]            f_value,
  input  wire logic [7:0]            literal,
  input  wire logic [2:0]            bit_pos,
  input  wire logic                  dest_to_file,
  output abx_pkg::abx_alu_out_t      result
);

  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] addend;
  logic [7:0] mask;

  always_comb begin
    addend  = (op == abx_pkg::OP_ADD_IMMEDIATE) ? literal : f_value;
    sum     = {1'b0, w_value} + {1'b0, addend};
    low_sum = {1'b0, w_value[3:0]} + {1'b0, addend[3:0]};
    mask    = abx_pkg::abx_bit_mask(bit_pos);
    result  = '0;
    case (op)
      abx_pkg::OP_ADD_IMMEDIATE: begin
        result.value     = sum[7:0];
        result.upd_carry = 1'b1;
        result.upd_zero  = 1'b1;
        result.to_w      = 1'b1;
      end
      abx_pkg::OP_ADD_REGISTER: begin
        result.value     = sum[7:0];
        result.upd_carry = 1'b1;
        result.upd_zero  = 1'b1;
        result.to_w      = !dest_to_file;
        result.to_file   = dest_to_file;
      end
      abx_pkg::OP_AND_IMMEDIATE: begin
        result.value    = w_value & literal;
        result.upd_zero = 1'b1;
        result.to_w     = 1'b1;
      end
      abx_pkg::OP_AND_REGISTER: begin
        result.value    = w_value & f_value;
        result.upd_zero = 1'b1;
        result.to_w     = !dest_to_file;
        result.to_file  = dest_to_file;
      end
      abx_pkg::OP_BIT_CLEAR: begin
        result.value   = f_value & ~mask;
        result.to_file = 1'b1;
      end
      abx_pkg::OP_BIT_SET: begin
        result.value   = f_value | mask;
        result.to_file = 1'b1;
      end
      abx_pkg::OP_TEST_SKIP_IF_ZERO: begin
        result.skip = ~|(f_value & mask);
      end
      abx_pkg::OP_TEST_SKIP_IF_ONE: begin
        result.skip = |(f_value & mask);
      end
      default: begin
        result = '0;
      end
    endcase
    result.flags.c  = sum[8];
    result.flags.hc = low_sum[4];
    result.flags.z  = (result.value == 8'h00);
  end

endmodule

// >>> logic/abx_exec.sv
// Execute stage for the add / AND / bit-op group, with an APB register slave.
// Assumes the fetch logic presents one instruction word per cycle with
// instr_valid, honours skip_cycle by treating the next word as discarded, and
// that the file register space returns read data in the same cycle as file_rd_addr.
//
// Local design decisions: the APB interface to the registers and the register offsets.

`timescale 1ns/1ps

module abx_exec (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Instruction from fetch
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr_word,
  output logic             instr_taken,
  output logic             skip_cycle,
  // File register space
  output logic [6:0]       file_rd_addr,
  input  wire logic [7:0]  file_rd_data,
  input  wire logic        file_is_io,
  input  wire logic [7:0]  pin_level,
  output logic             file_wr_en,
  output logic [6:0]       file_wr_addr,
  output logic [7:0]       file_wr_data,
  // Working register and flags
  output logic [7:0]       w_value,
  output abx_pkg::abx_flags_t flags,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  abx_pkg::abx_instr_t   dec;
  abx_pkg::abx_alu_out_t alu;
  abx_pkg::abx_flags_t   flags_q;
  logic [7:0]            w_q;
  logic [7:0]            operand;
  logic                  skip_q;
  logic                  exec_en_q;
  logic                  take;
  logic                  wr_en_q;
  logic [6:0]            wr_addr_q;
  logic [7:0]            wr_data_q;
  logic [15:0]           icnt_q;
  logic [31:0]           prdata_q;
  logic                  apb_setup;
  logic                  apb_write;
  logic                  addr_hit;
  logic [31:0]           read_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and operand selection
  always_comb begin
    dec = abx_pkg::abx_decode(instr_word);
  end

  // A skipped slot is consumed as a no-operation whatever word is offered
  assign take         = instr_valid && exec_en_q && !skip_q;
  assign instr_taken  = take;
  assign skip_cycle   = skip_q;
  assign file_rd_addr = dec.file_addr;

  // Pin levels win over the latch for I/O registers; otherwise forward a
  // write still in flight so back-to-back instructions see the new value.
  always_comb begin
    if (file_is_io) begin
      operand = pin_level;
    end else if (wr_en_q && (wr_addr_q == dec.file_addr)) begin
      operand = wr_data_q;
    end else begin
      operand = file_rd_data;
    end
  end

  abx_alu u_alu (
    .op           (take ? dec.op : abx_pkg::OP_NONE),
    .w_value      (w_q),
    .f_value      (operand),
    .literal      (dec.literal),
    .bit_pos      (dec.bit_pos),
    .dest_to_file (dec.dest_to_file),
    .result       (alu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite && addr_hit;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_hit;
  assign prdata    = prdata_q;

  always_comb begin
    addr_hit = 1'b1;
    read_mux = 32'h0000_0000;
    case (paddr)
      abx_pkg::OFF_CTRL: begin
        read_mux[abx_pkg::CTRL_EN_POS] = exec_en_q;
      end
      abx_pkg::OFF_WREG: begin
        read_mux[7:0] = w_q;
      end
      abx_pkg::OFF_STAT: begin
        read_mux[abx_pkg::STAT_C_POS]    = flags_q.c;
        read_mux[abx_pkg::STAT_HC_POS]   = flags_q.hc;
        read_mux[abx_pkg::STAT_Z_POS]    = flags_q.z;
        read_mux[abx_pkg::STAT_SKIP_POS] = skip_q;
      end
      abx_pkg::OFF_ICNT: begin
        read_mux[15:0] = icnt_q;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Read data is captured in the setup phase so prdata comes from a flop
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_q <= read_mux;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      exec_en_q <= abx_pkg::RST_EXEC_EN;
    end else if (apb_write && (paddr == abx_pkg::OFF_CTRL)) begin
      exec_en_q <= pwdata[abx_pkg::CTRL_EN_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working register: an executing instruction wins over a software write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      w_q <= abx_pkg::RST_WREG;
    end else if (alu.to_w) begin
      w_q <= alu.value;
    end else if (apb_write && (paddr == abx_pkg::OFF_WREG)) begin
      w_q <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: add updates all three, AND only Z, bit ops none
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= '0;
    end else if (alu.upd_carry || alu.upd_zero) begin
      if (alu.upd_carry) begin
        flags_q.c  <= alu.flags.c;
        flags_q.hc <= alu.flags.hc;
      end
      flags_q.z <= alu.flags.z;
    end else if (apb_write && (paddr == abx_pkg::OFF_STAT)) begin
      flags_q.c  <= pwdata[abx_pkg::STAT_C_POS];
      flags_q.hc <= pwdata[abx_pkg::STAT_HC_POS];
      flags_q.z  <= pwdata[abx_pkg::STAT_Z_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File write-back, one cycle after the instruction is taken
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_en_q   <= 1'b0;
      wr_addr_q <= 7'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_en_q <= alu.to_file;
      if (alu.to_file) begin
        wr_addr_q <= dec.file_addr;
        wr_data_q <= alu.value;
      end
    end
  end

  assign file_wr_en   = wr_en_q;
  assign file_wr_addr = wr_addr_q;
  assign file_wr_data = wr_data_q;
  assign w_value      = w_q;
  assign flags        = flags_q;

  ////////////////////////////////////////////////////////////////////////////
  // Skip: a true test turns the following slot into a no-operation
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= alu.skip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count of instructions executed from this group; wraps at 16 bits
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      icnt_q <= abx_pkg::RST_ICNT;
    end else if (apb_write && (paddr == abx_pkg::OFF_CTRL)
                 && pwdata[abx_pkg::CTRL_CLR_POS]) begin
      icnt_q <= abx_pkg::RST_ICNT;
    end else if (take && (dec.op != abx_pkg::OP_NONE)) begin
      icnt_q <= icnt_q + 16'h0001;
    end
  end

endmodule

// >>> logic/abx_pkg.sv
// Constants, types and decode helpers for the add / AND / bit-op execute block.
// Assumes a 14-bit instruction word and an 8-bit file register space with
// combinational read data; registers are reached over APB.
//
// Notes on behaviour
// - Add-immediate adds an 8-bit literal to W, writes W and updates carry, half-carry and Z.
// - Bit-clear forces bit b of file register f to zero and touches no flag.
// - Bit-set forces bit b of file register f to one and touches no flag.
// - Add-register adds W to file register f, sends the sum to the chosen place, sets all flags.
// - A byte-oriented result goes to W when the destination bit is 0, to f when it is 1.
// - AND-immediate ANDs W with an 8-bit literal into W and updates only Z.
// - AND-register ANDs W with f into the chosen destination and updates only Z.
// - Test-skip-if-zero skips the next instruction when bit b of f is 0, flags unchanged.
// - Test-skip-if-one skips the next instruction when bit b of f is 1, flags unchanged.
// - Byte-oriented words carry a 7-bit file address and one destination bit.
// - Bit-oriented words carry a 3-bit bit position beside the 7-bit file address.
// - An I/O register used as its own operand is read from the pin levels, not the latch.
// - When a skip test is true the extra second cycle runs as a no-operation.

package abx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // APB register map
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_WREG       = 8'h04;
  localparam logic [7:0]  OFF_STAT       = 8'h08;
  localparam logic [7:0]  OFF_ICNT       = 8'h0C;
  localparam int          CTRL_EN_POS    = 0;
  localparam int          CTRL_CLR_POS   = 1;
  localparam int          STAT_C_POS     = 0;
  localparam int          STAT_HC_POS    = 1;
  localparam int          STAT_Z_POS     = 2;
  localparam int          STAT_SKIP_POS  = 3;
  localparam logic        RST_EXEC_EN    = 1'b1;
  localparam logic [7:0]  RST_WREG       = 8'h00;
  localparam logic [15:0] RST_ICNT       = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction word fields and opcodes
  localparam int         FILE_LSB        = 0;
  localparam int         DEST_POS        = 7;
  localparam int         BIT_LSB         = 7;
  localparam int         LIT_LSB         = 0;
  localparam logic [5:0] OPC_ADD_REG     = 6'h07;
  localparam logic [5:0] OPC_AND_REG     = 6'h05;
  localparam logic [3:0] OPC_BIT_CLEAR   = 4'h4;
  localparam logic [3:0] OPC_BIT_SET     = 4'h5;
  localparam logic [3:0] OPC_TEST_ZERO   = 4'h6;
  localparam logic [3:0] OPC_TEST_ONE    = 4'h7;
  localparam logic [4:0] OPC_ADD_IMM     = 5'h1F;
  localparam logic [5:0] OPC_AND_IMM     = 6'h39;

  typedef enum logic [3:0] {
    OP_NONE              = 4'b0000,
    OP_ADD_IMMEDIATE     = 4'b0001,
    OP_ADD_REGISTER      = 4'b0010,
    OP_AND_IMMEDIATE     = 4'b0011,
    OP_AND_REGISTER      = 4'b0100,
    OP_BIT_CLEAR         = 4'b0101,
    OP_BIT_SET           = 4'b0110,
    OP_TEST_SKIP_IF_ZERO = 4'b0111,
    OP_TEST_SKIP_IF_ONE  = 4'b1000
  } abx_op_t;

  typedef struct packed {
    abx_op_t    op;
    logic [6:0] file_addr;
    logic       dest_to_file;
    logic [2:0] bit_pos;
    logic [7:0] literal;
  } abx_instr_t;

  typedef struct packed {
    logic c;
    logic hc;
    logic z;
  } abx_flags_t;

  typedef struct packed {
    logic [7:0] value;
    abx_flags_t flags;
    logic       upd_carry;
    logic       upd_zero;
    logic       to_w;
    logic       to_file;
    logic       skip;
  } abx_alu_out_t;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic abx_instr_t abx_decode(input logic [13:0] word);
    abx_instr_t d;
    d              = '0;
    d.op           = OP_NONE;
    d.file_addr    = word[FILE_LSB +: 7];
    d.dest_to_file = word[DEST_POS];
    d.bit_pos      = word[BIT_LSB +: 3];
    d.literal      = word[LIT_LSB +: 8];
    if (word[13:9] == OPC_ADD_IMM) d.op = OP_ADD_IMMEDIATE;
    else if (word[13:8] == OPC_AND_IMM) d.op = OP_AND_IMMEDIATE;
    else if (word[13:8] == OPC_ADD_REG) d.op = OP_ADD_REGISTER;
    else if (word[13:8] == OPC_AND_REG) d.op = OP_AND_REGISTER;
    else if (word[13:10] == OPC_BIT_CLEAR) d.op = OP_BIT_CLEAR;
    else if (word[13:10] == OPC_BIT_SET) d.op = OP_BIT_SET;
    else if (word[13:10] == OPC_TEST_ZERO) d.op = OP_TEST_SKIP_IF_ZERO;
    else if (word[13:10] == OPC_TEST_ONE) d.op = OP_TEST_SKIP_IF_ONE;
    return d;
  endfunction

  function automatic logic [7:0] abx_bit_mask(input logic [2:0] pos);
    return 8'h01 << pos;
  endfunction

endpackage

// >>> verification/abx_exec_properties.sv
// Checker for abx_exec: ties results, flags and skips to the word taken.
// Sees the ports of abx_exec only; attached by the bind at the foot.
`timescale 1ns/1ps
module abx_exec_properties (
  input wire logic                clk_sys,
  input wire logic                reset_n,
  input wire logic [13:0]         instr_word,
  input wire logic                instr_taken,
  input wire logic                skip_cycle,
  input wire logic [7:0]          file_rd_data,
  input wire logic                file_is_io,
  input wire logic [7:0]          pin_level,
  input wire logic                file_wr_en,
  input wire logic [6:0]          file_wr_addr,
  input wire logic [7:0]          file_wr_data,
  input wire logic [7:0]          w_value,
  input wire abx_pkg::abx_flags_t flags
);
  logic [13:0]         wd_q;
  logic [7:0]          op_q, w_q;
  abx_pkg::abx_flags_t fl_q;
  wire  [7:0]          opnd = file_is_io ? pin_level : file_rd_data;
  // Forwarded operands are left out: the file read data is stale then
  wire                 fwd  = file_wr_en && file_wr_addr == instr_word[6:0] && !file_is_io;
  wire                 tk   = instr_taken && !fwd;
  wire  [3:0]          hi   = instr_word[13:10];
  wire  [7:0]          msk  = 8'h01 << wd_q[9:7];
  always_ff @(posedge clk_sys) begin
    wd_q <= instr_word;
    op_q <= opnd;
    w_q  <= w_value;
    fl_q <= flags;
  end
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return {s[8], ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F, s[7:0] == 8'h00, s[7:0]};
  endfunction
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_ADD_IMM: assert property (tk && instr_word[13:9] == 5'h1F |=>
    {flags, w_value} == add8(w_q, wd_q[7:0])) else $error("add immediate result wrong");
  AST_ADD_REG: assert property (tk && instr_word[13:8] == 6'h07 |=>
    (wd_q[7] ? file_wr_en && {flags, file_wr_data} == add8(w_q, op_q) && w_value == w_q
             : !file_wr_en && {flags, w_value} == add8(w_q, op_q)))
    else $error("add register result wrong");
  AST_AND_IMM: assert property (tk && instr_word[13:8] == 6'h39 |=>
    w_value == (w_q & wd_q[7:0]) && flags == {fl_q.c, fl_q.hc, (w_q & wd_q[7:0]) == 8'h00})
    else $error("and immediate result wrong");
  AST_AND_REG: assert property (tk && instr_word[13:7] == 7'h0B |=>
    file_wr_en && file_wr_data == (w_q & op_q) && w_value == w_q
    && flags == {fl_q.c, fl_q.hc, (w_q & op_q) == 8'h00})
    else $error("and register result wrong");
  AST_BIT_CLR: assert property (tk && hi == 4'h4 |=>
    file_wr_en && file_wr_addr == wd_q[6:0] && file_wr_data == (op_q & ~msk) && flags == fl_q)
    else $error("bit clear result wrong");
  AST_BIT_SET: assert property (tk && hi == 4'h5 |=>
    file_wr_en && file_wr_data == (op_q | msk) && flags == fl_q)
    else $error("bit set result wrong");
  AST_TEST: assert property (tk && hi[3:1] == 3'b011 |=>
    skip_cycle == (op_q[wd_q[9:7]] == wd_q[10]) && flags == fl_q && !file_wr_en)
    else $error("skip test outcome wrong");
  AST_SKIP_NOP: assert property (skip_cycle |-> !instr_taken ##1
    (!skip_cycle && w_value == w_q && flags == fl_q && !file_wr_en))
    else $error("skip slot not a no-operation");
  cover property (skip_cycle);
  cover property (tk && file_is_io && hi == 4'h5);
  cover property (fwd && instr_taken);
endmodule
bind abx_exec abx_exec_properties chk_u (.clk_sys, .reset_n, .instr_word, .instr_taken,
  .skip_cycle, .file_rd_data, .file_is_io, .pin_level, .file_wr_en, .file_wr_addr,
  .file_wr_data, .w_value, .flags);

// >>> verification/abx_exec_tb.sv
// Bench for abx_exec: runs each instruction of the group and the APB slave.
// Assumes abx_file_model answers reads in the same cycle.
`timescale 1ns/1ps
module abx_exec_tb;
  logic                clk_sys, reset_n, instr_valid, psel, penable, pwrite, er, tk, sk;
  logic                instr_taken, skip_cycle, file_is_io, file_wr_en, pready, pslverr;
  logic [13:0]         instr_word;
  logic [6:0]          file_rd_addr, file_wr_addr;
  logic [7:0]          file_rd_data, pin_level, file_wr_data, w_value, paddr, wv;
  logic [31:0]         pwdata, prdata, rd;
  abx_pkg::abx_flags_t flags;
  int                  bad_count, checks;
  abx_exec dut_u (.clk_sys, .reset_n, .instr_valid, .instr_word, .instr_taken, .skip_cycle,
    .file_rd_addr, .file_rd_data, .file_is_io, .pin_level, .file_wr_en, .file_wr_addr,
    .file_wr_data, .w_value, .flags, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  abx_file_model part_u (.clk_sys, .file_rd_addr, .file_rd_data, .file_is_io, .file_wr_en,
    .file_wr_addr, .file_wr_data);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Skip slot is read at the falling edge, where it is settled
  task automatic ex(input logic [13:0] w);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(negedge clk_sys);
    tk = instr_taken;
    sk = skip_cycle;
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    instr_valid <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic end_sim;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, instr_valid, psel, penable, pwrite} = 5'h00;
    instr_word = 14'h0000;
    paddr      = 8'h00;
    pwdata     = 32'h0000_0000;
    pin_level  = 8'h0f;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, abx_pkg::OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(er, 1'b1);
    // Sum wraps to zero: all three flags rise together
    apb(1'b1, abx_pkg::OFF_WREG, 32'h0000_0088);
    ex(14'h3E78);
    idle(1);
    chk({flags, w_value}, 32'h0000_0700);
    apb(1'b0, abx_pkg::OFF_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    ex(14'h3F05);
    idle(1);
    chk({flags, w_value}, 32'h0000_0005);
    part_u.mem[7'h20] = 8'hfb;
    part_u.mem[7'h21] = 8'hff;
    ex(14'h07A0);
    idle(2);
    chk({flags, w_value, part_u.mem[7'h20]}, 32'h0007_0500);
    ex(14'h0721);
    idle(2);
    chk({flags, w_value, part_u.mem[7'h21]}, 32'h0006_04ff);
    ex(14'h39F0);
    idle(1);
    chk({flags, w_value}, 32'h0000_0700);
    apb(1'b1, abx_pkg::OFF_WREG, 32'h0000_00f5);
    part_u.mem[7'h22] = 8'h3c;
    ex(14'h05A2);
    idle(2);
    chk({flags, w_value, part_u.mem[7'h22]}, 32'h0006_f534);
    // Back to back on one cell, so each op after the first leans on the pending write
    part_u.mem[7'h30] = 8'hff;
    part_u.mem[7'h31] = 8'h00;
    for (int b = 0; b < 8; b += 2) ex({4'h4, 3'(b), 7'h30});
    for (int b = 0; b < 8; b += 2) ex({4'h5, 3'(b), 7'h31});
    idle(2);
    chk({flags, part_u.mem[7'h30], part_u.mem[7'h31]}, 32'h0006_aa55);
    part_u.mem[7'h05] = 8'hff;
    ex({4'h5, 3'd7, 7'h05});
    idle(2);
    chk(part_u.mem[7'h05], 8'h8f);
    for (int i = 0; i < 4; i++) begin
      wv = w_value;
      ex({i[1] ? 4'h7 : 4'h6, 2'b00, i[0] ^ i[1], 7'h30});
      ex(14'h3E01);
      chk({tk, sk}, {i[0], ~i[0]});
      idle(1);
      chk(w_value, i[0] ? 8'(wv + 8'h01) : wv);
    end
    // Disabled core refuses words; count clear rides on the same write
    wv = w_value;
    apb(1'b1, abx_pkg::OFF_CTRL, 32'h0000_0002);
    ex(14'h3E01);
    idle(1);
    chk({tk, w_value}, {1'b0, wv});
    apb(1'b0, abx_pkg::OFF_ICNT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, abx_pkg::OFF_CTRL, 32'h0000_0001);
    // Re-enabled core counts again from the cleared value
    ex(14'h3E01);
    idle(1);
    apb(1'b0, abx_pkg::OFF_ICNT, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    end_sim();
  end
endmodule

// >>> verification/abx_file_model.sv
// File register space beside abx_exec: 128 bytes, combinational read.
// Assumes writes arrive as one-cycle strobes; IO_ADDR holds a port latch.
`timescale 1ns/1ps
module abx_file_model #(
  parameter logic [6:0] IO_ADDR = 7'h05
) (
  input  wire logic       clk_sys,
  input  wire logic [6:0] file_rd_addr,
  output logic [7:0]      file_rd_data,
  output logic            file_is_io,
  input  wire logic       file_wr_en,
  input  wire logic [6:0] file_wr_addr,
  input  wire logic [7:0] file_wr_data
);
  logic [7:0] mem [128];
  // Port slot returns its latch, so an operand not taken from the pins shows
  assign file_rd_data = mem[file_rd_addr];
  assign file_is_io   = file_rd_addr == IO_ADDR;
  // Plain always: the bench preloads cells between instructions
  always @(posedge clk_sys) begin
    if (file_wr_en) begin
      mem[file_wr_addr] <= file_wr_data;
    end
  end
endmodule
